// *** hdl/source_address_matcher.sv ***
// source address matcher with apb registers and table memory
`timescale 1ns/10ps

// Operation
// - short enable bit n enables short entry n, entries 0 to 23.
// - long enable bit 2n enables long entry n.
// - long enable odd bit 2n+1 reads back as bit 2n.
// - match only when enabled and frame accepted; enable resets to one.
// - source mode 2 uses short compare, mode 3 long compare.
// - short entry hits when enabled and pan id and short match.
// - long entry hits when enabled and long address matches; all 12 scanned.
// - mask cleared per pass; one bit per hitting short entry.
// - hitting long entry n sets mask bits 2n and 2n+1.
// - index is 0x3F with no source address or no hit.
// - index bits 4:0 hold the lowest hitting entry number.
// - index bit 5 is zero for short, one for long hit.
// - index bit 6 carries the automatic frame pending outcome.
// - mask and index are written to memory when matching completes.
// - with checksum and append set, index replaces status link quality field.
// - table at 0x380; short n at plus 4n, long n at plus 8n.
// - table words are little-endian like received frames.
// - done event always; found event one cycle before done on hit.
module source_address_matcher (
  // clock, reset, enable
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // frame filter side
  input wire logic FRAME_ACCEPTED_I,
  input wire logic [1:0] SRC_MODE_I,
  input wire logic [15:0] SRC_PANID_I,
  input wire logic [15:0] SRC_SHORT_I,
  input wire logic [63:0] SRC_LONG_I,
  input wire logic [6:0] LQI_I,
  // results and events
  output logic MATCH_FOUND_O,
  output logic MATCH_DONE_O,
  output logic [23:0] RESULT_MASK_O,
  output logic [6:0] RESULT_INDEX_O,
  output logic APPEND_INDEX_O,
  output logic [6:0] STATUS_LQI_O
);

  typedef struct packed {
    match_control_pkg::match_state_t st;
    logic [4:0] word;
    logic is_long;
    logic low_ok;
    logic [23:0] mask;
    logic [6:0] idx;
    logic [15:0] panid;
    logic [15:0] shrt;
    logic [63:0] long_addr;
    logic [23:0] short_en;
    logic [11:0] long_en;
    logic [1:0] match_control;
    logic [1:0] frame_control;
    logic ram_pend;
    logic found_ev;
    logic done_ev;
    logic [6:0] lqi_out;
  } core_state_t;

  core_state_t q;
  core_state_t d;

  logic ram_we;
  logic [4:0] ram_addr;
  logic [31:0] ram_wdata;
  logic [31:0] ram_rdata;
  logic hit;
  logic entry_en;
  logic access;
  logic reg_write;
  logic ram_sel;
  logic reg_sel;
  logic [31:0] reg_rdata;
  logic [23:0] long_rd;

  // long enables read back with each bit doubled
  function automatic logic [23:0] mirror(input logic [11:0] en);
    logic [23:0] v;
    v = 24'h000000;
    for (int n = 0; n < 12; n++)
    begin
      v[2*n] = en[n];
      v[2*n+1] = en[n];
    end
    return v;
  endfunction : mirror

  // keep only the even bits of a written long enable byte
  function automatic logic [3:0] even_bits(input logic [7:0] b);
    return {b[6], b[4], b[2], b[0]};
  endfunction : even_bits

  // address falls in the table and result words
  function automatic logic in_ram(input logic [11:0] a);
    return (a >= match_control_pkg::TABLE_BASE) && (a < match_control_pkg::RAM_END);
  endfunction : in_ram

  // address names a control register
  function automatic logic is_reg(input logic [11:0] a);
    return (a[11:2] <= match_control_pkg::OFS_FRAME_CONTROL_ZERO[11:2]);
  endfunction : is_reg

  assign access = PSEL_I && PENABLE_I;
  assign ram_sel = in_ram(PADDR_I);
  assign reg_sel = is_reg(PADDR_I);
  assign reg_write = access && PWRITE_I && reg_sel;
  assign long_rd = mirror(q.long_en);

  // entry enable for the word under compare
  always_comb
  begin
    if (q.is_long)
    begin
      entry_en = q.long_en[q.word[4:1]];
    end
    else
    begin
      entry_en = q.short_en[q.word];
    end
  end

  entry_compare u_compare (
    .word_i(ram_rdata),
    .long_i(q.is_long),
    .high_i(q.word[0]),
    .panid_i(q.panid),
    .short_i(q.shrt),
    .long_addr_i(q.long_addr),
    .hit_o(hit)
  );

  table_ram u_ram (
    .clk_i(MCLK_I),
    .rstn_i(RSTN_I),
    .ce_i(CE_I),
    .we_i(ram_we),
    .addr_i(ram_addr),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata)
  );

  // register read mux
  always_comb
  begin
    reg_rdata = 32'h00000000;
    unique case (PADDR_I[11:2])
      match_control_pkg::OFS_SHORT_EN_LOW[11:2]: reg_rdata = {24'h000000, q.short_en[7:0]};
      match_control_pkg::OFS_SHORT_EN_MID[11:2]: reg_rdata = {24'h000000, q.short_en[15:8]};
      match_control_pkg::OFS_SHORT_EN_HIGH[11:2]: reg_rdata = {24'h000000, q.short_en[23:16]};
      match_control_pkg::OFS_LONG_EN_LOW[11:2]: reg_rdata = {24'h000000, long_rd[7:0]};
      match_control_pkg::OFS_LONG_EN_MID[11:2]: reg_rdata = {24'h000000, long_rd[15:8]};
      match_control_pkg::OFS_LONG_EN_HIGH[11:2]: reg_rdata = {24'h000000, long_rd[23:16]};
      match_control_pkg::OFS_MATCH_CONTROL[11:2]: reg_rdata = {30'h00000000, q.match_control};
      match_control_pkg::OFS_FRAME_CONTROL_ZERO[11:2]: reg_rdata = {30'h00000000, q.frame_control};
      default: reg_rdata = 32'h00000000;
    endcase
  end

  // apb answer: registers at once, memory one cycle after the matcher is idle
  always_comb
  begin
    if (ram_sel)
    begin
      PREADY_O = access && q.ram_pend;
      PRDATA_O = (access && q.ram_pend && !PWRITE_I) ? ram_rdata : 32'h00000000;
    end
    else
    begin
      PREADY_O = access;
      PRDATA_O = (access && !PWRITE_I && reg_sel) ? reg_rdata : 32'h00000000;
    end
    PSLVERR_O = access && !ram_sel && !reg_sel;
  end

  always_comb
  begin
    d = q;
    d.found_ev = 1'b0;
    d.done_ev = 1'b0;
    ram_we = 1'b0;
    ram_addr = PADDR_I[6:2];
    ram_wdata = PWDATA_I;

    // control register writes
    if (reg_write)
    begin
      unique case (PADDR_I[11:2])
        match_control_pkg::OFS_SHORT_EN_LOW[11:2]: d.short_en[7:0] = PWDATA_I[7:0];
        match_control_pkg::OFS_SHORT_EN_MID[11:2]: d.short_en[15:8] = PWDATA_I[7:0];
        match_control_pkg::OFS_SHORT_EN_HIGH[11:2]: d.short_en[23:16] = PWDATA_I[7:0];
        match_control_pkg::OFS_LONG_EN_LOW[11:2]: d.long_en[3:0] = even_bits(PWDATA_I[7:0]);
        match_control_pkg::OFS_LONG_EN_MID[11:2]: d.long_en[7:4] = even_bits(PWDATA_I[7:0]);
        match_control_pkg::OFS_LONG_EN_HIGH[11:2]: d.long_en[11:8] = even_bits(PWDATA_I[7:0]);
        match_control_pkg::OFS_MATCH_CONTROL[11:2]: d.match_control = PWDATA_I[1:0];
        match_control_pkg::OFS_FRAME_CONTROL_ZERO[11:2]: d.frame_control = PWDATA_I[1:0];
        default: d.short_en = q.short_en;
      endcase
    end

    // memory access from apb, only while the matcher is idle
    if (q.ram_pend)
    begin
      d.ram_pend = 1'b0;
    end
    else if (access && ram_sel && (q.st == match_control_pkg::ST_IDLE))
    begin
      d.ram_pend = 1'b1;
      ram_we = PWRITE_I && (PADDR_I[6:2] <= match_control_pkg::LAST_TABLE_WORD);
    end

    unique case (q.st)
      match_control_pkg::ST_IDLE:
      begin
        if (FRAME_ACCEPTED_I && q.match_control[match_control_pkg::MATCH_ENABLE_BIT])
        begin
          d.mask = 24'h000000;
          d.idx = match_control_pkg::INDEX_NONE;
          d.word = 5'h00;
          d.low_ok = 1'b0;
          d.panid = SRC_PANID_I;
          d.shrt = SRC_SHORT_I;
          d.long_addr = SRC_LONG_I;
          d.is_long = (SRC_MODE_I == match_control_pkg::MODE_LONG);
          if ((SRC_MODE_I == match_control_pkg::MODE_SHORT) || (SRC_MODE_I == match_control_pkg::MODE_LONG))
          begin
            d.st = match_control_pkg::ST_READ;
          end
          else
          begin
            d.st = match_control_pkg::ST_WMASK;
          end
        end
      end
      match_control_pkg::ST_READ:
      begin
        ram_addr = q.word;
        d.st = match_control_pkg::ST_CMP;
      end
      match_control_pkg::ST_CMP:
      begin
        ram_addr = q.word;
        if (q.is_long)
        begin
          if (!q.word[0])
          begin
            d.low_ok = entry_en && hit;
          end
          else if (q.low_ok && entry_en && hit)
          begin
            d.mask[{q.word[4:1], 1'b0}] = 1'b1;
            d.mask[{q.word[4:1], 1'b1}] = 1'b1;
            if (q.idx == match_control_pkg::INDEX_NONE)
            begin
              d.idx = {2'b01, 1'b0, q.word[4:1]};
            end
          end
        end
        else if (entry_en && hit)
        begin
          d.mask[q.word] = 1'b1;
          if (q.idx == match_control_pkg::INDEX_NONE)
          begin
            d.idx = {2'b00, q.word};
          end
        end
        if (q.word == match_control_pkg::LAST_TABLE_WORD)
        begin
          d.st = match_control_pkg::ST_WMASK;
        end
        else
        begin
          d.word = q.word + 5'h01;
          d.st = match_control_pkg::ST_READ;
        end
      end
      match_control_pkg::ST_WMASK:
      begin
        ram_we = 1'b1;
        ram_addr = match_control_pkg::RES_MASK_WORD;
        ram_wdata = {8'h00, q.mask};
        if ((q.idx != match_control_pkg::INDEX_NONE) && q.match_control[match_control_pkg::AUTO_FRAME_PENDING_BIT])
        begin
          d.idx[match_control_pkg::INDEX_PEND_BIT] = 1'b1;
        end
        d.st = match_control_pkg::ST_WIDX;
      end
      match_control_pkg::ST_WIDX:
      begin
        ram_we = 1'b1;
        ram_addr = match_control_pkg::RES_INDEX_WORD;
        ram_wdata = {25'h0000000, q.idx};
        d.found_ev = (q.idx != match_control_pkg::INDEX_NONE);
        d.st = match_control_pkg::ST_DONE;
      end
      match_control_pkg::ST_DONE:
      begin
        d.done_ev = 1'b1;
        d.st = match_control_pkg::ST_IDLE;
      end
    endcase

    // link quality field of the status word
    if (q.frame_control[match_control_pkg::AUTO_CHECKSUM_BIT] && q.frame_control[match_control_pkg::APPEND_INFO_SELECT_BIT])
    begin
      d.lqi_out = q.idx;
    end
    else
    begin
      d.lqi_out = LQI_I;
    end
  end

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      q <= '0;
      q.st <= match_control_pkg::ST_IDLE;
      q.idx <= match_control_pkg::INDEX_NONE;
      q.short_en <= match_control_pkg::SHORT_EN_RST;
      q.long_en <= match_control_pkg::LONG_EN_RST;
      q.match_control <= match_control_pkg::MATCH_CONTROL_RST;
      q.frame_control <= match_control_pkg::FRAME_CONTROL_ZERO_RST;
    end
    else if (CE_I)
    begin
      q <= d;
    end
  end

  assign MATCH_FOUND_O = q.found_ev;
  assign MATCH_DONE_O = q.done_ev;
  assign RESULT_MASK_O = q.mask;
  assign RESULT_INDEX_O = q.idx;
  assign APPEND_INDEX_O = q.frame_control[match_control_pkg::AUTO_CHECKSUM_BIT] &&
                          q.frame_control[match_control_pkg::APPEND_INFO_SELECT_BIT];
  assign STATUS_LQI_O = q.lqi_out;

endmodule : source_address_matcher

// *** hdl/match_control_pkg.sv ***
// constants and types shared by the source address matcher
package match_control_pkg;

  // register byte offsets
  localparam logic [11:0] OFS_SHORT_EN_LOW = 12'h000;
  localparam logic [11:0] OFS_SHORT_EN_MID = 12'h004;
  localparam logic [11:0] OFS_SHORT_EN_HIGH = 12'h008;
  localparam logic [11:0] OFS_LONG_EN_LOW = 12'h00C;
  localparam logic [11:0] OFS_LONG_EN_MID = 12'h010;
  localparam logic [11:0] OFS_LONG_EN_HIGH = 12'h014;
  localparam logic [11:0] OFS_MATCH_CONTROL = 12'h018;
  localparam logic [11:0] OFS_FRAME_CONTROL_ZERO = 12'h01C;

  // table and result words in ram
  localparam logic [11:0] TABLE_BASE = 12'h380;
  localparam logic [11:0] RAM_END = 12'h3E8;
  localparam int RAM_WORDS = 26;
  localparam logic [4:0] LAST_TABLE_WORD = 5'h17;
  localparam logic [4:0] RES_MASK_WORD = 5'h18;
  localparam logic [4:0] RES_INDEX_WORD = 5'h19;

  // match_control fields
  localparam int MATCH_ENABLE_BIT = 0;
  localparam int AUTO_FRAME_PENDING_BIT = 1;
  localparam logic [1:0] MATCH_CONTROL_RST = 2'h1;

  // frame_control_zero fields
  localparam int AUTO_CHECKSUM_BIT = 0;
  localparam int APPEND_INFO_SELECT_BIT = 1;
  localparam logic [1:0] FRAME_CONTROL_ZERO_RST = 2'h0;

  // enable reset values
  localparam logic [23:0] SHORT_EN_RST = 24'h000000;
  localparam logic [11:0] LONG_EN_RST = 12'h000;

  // result index encoding
  localparam logic [6:0] INDEX_NONE = 7'h3F;
  localparam int INDEX_LONG_BIT = 5;
  localparam int INDEX_PEND_BIT = 6;

  // source address modes
  localparam logic [1:0] MODE_SHORT = 2'h2;
  localparam logic [1:0] MODE_LONG = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_CMP,
    ST_WMASK,
    ST_WIDX,
    ST_DONE
  } match_state_t;

endpackage : match_control_pkg

// *** hdl/table_ram.sv ***
// word memory holding the address table and the match results
`timescale 1ns/10ps
module table_ram (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  // access port
  input wire logic we_i,
  input wire logic [4:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic [31:0] rdata_o
);

  typedef struct packed {
    logic [match_control_pkg::RAM_WORDS-1:0][31:0] mem;
    logic [31:0] rdata;
  } ram_state_t;

  ram_state_t q;
  ram_state_t d;

  always_comb
  begin
    d = q;
    d.rdata = q.mem[addr_i];
    if (we_i)
    begin
      d.mem[addr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q <= '0;
    end
    else if (ce_i)
    begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;

endmodule : table_ram

// *** hdl/entry_compare.sv ***
// compares one table word with the received source address
`timescale 1ns/10ps
module entry_compare (
  // table word and position
  input wire logic [31:0] word_i,
  input wire logic long_i,
  input wire logic high_i,
  // received source address
  input wire logic [15:0] panid_i,
  input wire logic [15:0] short_i,
  input wire logic [63:0] long_addr_i,
  // result
  output logic hit_o
);

  // little-endian: pan id in the low half, short address above
  always_comb
  begin
    if (!long_i)
    begin
      hit_o = (word_i == {short_i, panid_i});
    end
    else if (high_i)
    begin
      hit_o = (word_i == long_addr_i[63:32]);
    end
    else
    begin
      hit_o = (word_i == long_addr_i[31:0]);
    end
  end

endmodule : entry_compare

// *** tb/source_address_matcher_monitor.sv ***
// assertions on the matcher result ports
`timescale 1ns/10ps
module source_address_matcher_monitor (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic RSTN_I,
  // frame side and results
  input wire logic FRAME_ACCEPTED_I,
  input wire logic [6:0] LQI_I,
  input wire logic MATCH_FOUND_O,
  input wire logic MATCH_DONE_O,
  input wire logic [23:0] RESULT_MASK_O,
  input wire logic [6:0] RESULT_INDEX_O,
  input wire logic APPEND_INDEX_O,
  input wire logic [6:0] STATUS_LQI_O
);
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);
  logic [7:0] age_q;
  logic [7:0] age_d;
  logic [4:0] low2;
  assign low2 = {RESULT_INDEX_O[3:0], 1'b0};
  always_comb age_d = FRAME_ACCEPTED_I ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
  always_ff @(posedge MCLK_I or negedge RSTN_I)
    if (!RSTN_I) age_q <= 8'hFF;
    else age_q <= age_d;
  a_found_then_done: assert property (MATCH_FOUND_O |=> MATCH_DONE_O)
    else $error("done missing");
  a_miss_gives_none: assert property (MATCH_DONE_O && !$past(MATCH_FOUND_O) |-> RESULT_INDEX_O == 7'h3F)
    else $error("index not none");
  a_hit_sets_mask: assert property (MATCH_DONE_O |-> $past(MATCH_FOUND_O) == (RESULT_MASK_O != 24'h0))
    else $error("mask and found disagree");
  a_short_lowest_hit: assert property (MATCH_FOUND_O && !RESULT_INDEX_O[5] |-> RESULT_INDEX_O[4:0] < 5'h18
    && RESULT_MASK_O[RESULT_INDEX_O[4:0]] && (RESULT_MASK_O << (5'h18 - RESULT_INDEX_O[4:0])) == 24'h0)
    else $error("short index wrong");
  a_long_pair_hit: assert property (MATCH_FOUND_O && RESULT_INDEX_O[5] |-> RESULT_INDEX_O[4:0] < 5'h0C
    && RESULT_MASK_O[low2+:2] == 2'h3 && (RESULT_MASK_O << (5'h18 - low2)) == 24'h0
    && (RESULT_MASK_O & 24'h555555) == ((RESULT_MASK_O >> 1) & 24'h555555))
    else $error("long mask wrong");
  a_results_hold: assert property ($changed(RESULT_MASK_O) || $changed(RESULT_INDEX_O) |-> age_q < 8'h3C)
    else $error("result moved");
  a_status_index: assert property ($past(RSTN_I) && $past(APPEND_INDEX_O) |-> STATUS_LQI_O == $past(RESULT_INDEX_O))
    else $error("status not index");
  a_status_lqi: assert property ($past(RSTN_I) && !$past(APPEND_INDEX_O) |-> STATUS_LQI_O == $past(LQI_I))
    else $error("status not lqi");
  c_short_hit: cover property (MATCH_FOUND_O && !RESULT_INDEX_O[5]);
  c_long_hit: cover property (MATCH_FOUND_O && RESULT_INDEX_O[5]);
  c_miss: cover property (MATCH_DONE_O && !$past(MATCH_FOUND_O));
endmodule : source_address_matcher_monitor

// *** tb/frame_source.sv ***
// frame filter model handing accepted frames to the matcher
`timescale 1ns/10ps
module frame_source (
  // clock
  input wire logic clk_i,
  // accepted frame
  output logic accepted_o,
  output logic [1:0] mode_o,
  output logic [15:0] panid_o,
  output logic [15:0] short_o,
  output logic [63:0] long_o
);
  initial {accepted_o, mode_o, panid_o, short_o, long_o} = '0;
  // fields valid in the pulse cycle only
  task automatic send(input logic [1:0] m, input logic [15:0] p, input logic [15:0] s, input logic [63:0] l);
    @(posedge clk_i);
    accepted_o <= 1'b1;
    {mode_o, panid_o, short_o, long_o} <= {m, p, s, l};
    @(posedge clk_i);
    accepted_o <= 1'b0;
    {mode_o, panid_o, short_o, long_o} <= ~{m, p, s, l};
  endtask : send
endmodule : frame_source

// *** tb/source_address_matcher_tb.sv ***
// self-checking bench for the source address matcher
`timescale 1ns/10ps
module source_address_matcher_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [6:0] lqi = 7'h00;
  logic acc;
  logic [1:0] md;
  logic [15:0] pan;
  logic [15:0] shr;
  logic [63:0] lng;
  logic [31:0] prd;
  logic rdy;
  logic slv;
  logic fnd;
  logic dn;
  logic [23:0] msk;
  logic [6:0] idx;
  logic app;
  logic [6:0] st;
  int n_fail = 0;
  int comparisons = 0;
  int seed = 59;
  int n;
  int k;
  logic [31:0] tbl [24];
  logic [23:0] sh_en;
  logic [11:0] lg_en;
  logic [23:0] lw;
  logic pend;
  logic [31:0] rd;
  logic err;
  logic [30:0] ex;
  logic [1:0] fc = 2'h0;
  always #25 clk = ~clk;
  frame_source src (.clk_i(clk), .accepted_o(acc), .mode_o(md), .panid_o(pan), .short_o(shr), .long_o(lng));
  source_address_matcher DUT (.MCLK_I(clk), .RSTN_I(rstn), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy), .PSLVERR_O(slv),
    .FRAME_ACCEPTED_I(acc), .SRC_MODE_I(md), .SRC_PANID_I(pan), .SRC_SHORT_I(shr), .SRC_LONG_I(lng),
    .LQI_I(lqi), .MATCH_FOUND_O(fnd), .MATCH_DONE_O(dn), .RESULT_MASK_O(msk), .RESULT_INDEX_O(idx),
    .APPEND_INDEX_O(app), .STATUS_LQI_O(st));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    {psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (rdy !== 1'b1 && t < 200)
    begin
      @(posedge clk);
      t++;
    end
    rd = prd;
    err = slv;
    {psel, pen} <= 2'b00;
    if (t >= 200) n_fail++;
  endtask : apb
  function automatic logic [23:0] spread(input logic [11:0] e);
    for (int i = 0; i < 12; i++) spread[2*i+:2] = {2{e[i]}};
  endfunction : spread
  function automatic logic [30:0] expect_res(input logic [1:0] m, input logic [15:0] p, input logic [15:0] s,
    input logic [63:0] l);
    logic [23:0] mk;
    logic [6:0] ix;
    mk = 24'h0;
    ix = 7'h3F;
    for (int i = 0; i < 24; i++)
      if (m == 2'h2 && sh_en[i] && tbl[i] === {s, p})
      begin
        mk[i] = 1'b1;
        if (ix == 7'h3F) ix = 7'(i);
      end
    for (int i = 0; i < 12; i++)
      if (m == 2'h3 && lg_en[i] && {tbl[2*i+1], tbl[2*i]} === l)
      begin
        mk[2*i+:2] = 2'h3;
        if (ix == 7'h3F) ix = 7'h20 | 7'(i);
      end
    if (ix != 7'h3F && pend) ix[6] = 1'b1;
    return {mk, ix};
  endfunction : expect_res
  task automatic frame(input logic [1:0] m, input logic [15:0] p, input logic [15:0] s, input logic [63:0] l);
    logic hit;
    ex = expect_res(m, p, s, l);
    hit = 1'b0;
    k = 0;
    lqi <= 7'($random(seed));
    src.send(m, p, s, l);
    do
    begin
      @(negedge clk);
      if (fnd === 1'b1) hit = 1'b1;
      k++;
    end
    while (dn !== 1'b1 && k < 100);
    check("done", {31'h0, dn}, 32'h1);
    check("found", {31'h0, hit}, {31'h0, ex[6:0] != 7'h3F});
    check("mask", {8'h0, msk}, {8'h0, ex[30:7]});
    check("index", {25'h0, idx}, {25'h0, ex[6:0]});
    check("append", {31'h0, app}, {31'h0, fc == 2'h3});
    check("status", {25'h0, st}, {25'h0, (fc == 2'h3) ? ex[6:0] : lqi});
    apb(1'b0, 12'h3E0, 32'h0);
    check("ram mask", rd, {8'h0, ex[30:7]});
    apb(1'b0, 12'h3E4, 32'h0);
    check("ram index", rd, {25'h0, ex[6:0]});
  endtask : frame
  initial
  begin
    #2000000;
    n_fail++;
    complete_run();
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 12'(4 * i), 32'h0);
      check("reset", rd, {31'h0, i == 6});
    end
    apb(1'b1, 12'h020, 32'hFF);
    check("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h00C, 32'hA6);
    apb(1'b0, 12'h00C, 32'h0);
    check("odd bits", rd, 32'h0C);
    apb(1'b1, 12'h3E0, 32'h1);
    apb(1'b0, 12'h3E0, 32'h0);
    check("ro word", rd, 32'h0);
    for (int w = 0; w < 24; w++)
      tbl[w] = $random(seed);
    tbl[7] = tbl[3];
    tbl[20] = tbl[18];
    tbl[21] = tbl[19];
    for (int w = 0; w < 24; w++)
      apb(1'b1, match_control_pkg::TABLE_BASE + 12'(4 * w), tbl[w]);
    for (int i = 0; i < 28; i++)
    begin
      sh_en = (i == 0) ? 24'h000088 : $random(seed) & 24'h000FFF;
      lg_en = (i == 1) ? 12'hE00 : $random(seed) & 12'hFC0;
      pend = $random(seed);
      lw = spread(lg_en) | ($random(seed) & 24'hAAAAAA);
      for (int j = 0; j < 3; j++)
      begin
        apb(1'b1, 12'(4 * j), {24'h0, sh_en[8*j+:8]});
        apb(1'b1, 12'(12 + 4 * j), {24'h0, lw[8*j+:8]});
      end
      apb(1'b1, 12'h018, {30'h0, pend, 1'b1});
      fc = 2'($random(seed));
      apb(1'b1, 12'h01C, {30'h0, fc});
      n = (i == 0) ? 7 : (i == 1) ? 10 : {$random(seed)} % 12;
      k = 6 + n % 6;
      frame((i < 2) ? 2'(i + 2) : 2'($random(seed)), tbl[n][15:0] ^ 16'(i > 1 && n > 9), tbl[n][31:16],
        {tbl[2*k+1], tbl[2*k]} ^ 64'(i > 1 && n < 2));
    end
    apb(1'b1, 12'h018, 32'h0);
    src.send(2'h2, tbl[3][15:0], tbl[3][31:16], 64'h0);
    n = 0;
    repeat (70)
    begin
      @(negedge clk);
      if (dn === 1'b1) n++;
    end
    check("disabled", 32'(n), 32'h0);
    check("held", {8'h0, msk}, {8'h0, ex[30:7]});
    complete_run();
  end
endmodule : source_address_matcher_tb
bind source_address_matcher source_address_matcher_monitor mon (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I),
  .FRAME_ACCEPTED_I(FRAME_ACCEPTED_I), .LQI_I(LQI_I), .MATCH_FOUND_O(MATCH_FOUND_O), .MATCH_DONE_O(MATCH_DONE_O),
  .RESULT_MASK_O(RESULT_MASK_O), .RESULT_INDEX_O(RESULT_INDEX_O), .APPEND_INDEX_O(APPEND_INDEX_O),
  .STATUS_LQI_O(STATUS_LQI_O));
